// ==== include/prc_regs.svh ====
// register map and field layout of the previous-result capture block
// assumes an 8-bit special-function register space on a plain port
`ifndef PRC_REGS_SVH
`define PRC_REGS_SVH

`define PRC_ADDR_PREV0 8'hc4
`define PRC_ADDR_PREV1 8'hc5
`define PRC_ADDR_PREV2 8'hc6
`define PRC_ADDR_PREV3 8'hc7
`define PRC_ADDR_CONFIG 8'hc8
`define PRC_ADDR_OPA_LO 8'hc9
`define PRC_ADDR_OPA_HI 8'hca

`define PRC_LANE_W 8
`define PRC_LANES 4

`define PRC_CFG_MODE_BIT 0
`define PRC_CFG_REQ_BIT 1
`define PRC_CFG_MUL_LSB 2
`define PRC_CFG_MUL_MSB 3
`define PRC_CFG_ADD_LSB 4
`define PRC_CFG_ADD_MSB 5

`define PRC_MODE_AUTO 1'h0
`define PRC_MODE_MANUAL 1'h1

`define PRC_MUL_A_B 2'h0
`define PRC_MUL_A_A 2'h1
`define PRC_MUL_A_PREV 2'h2
`define PRC_MUL_A_A_ALT 2'h3

`define PRC_ADD_NONE 2'h0
`define PRC_ADD_C 2'h1
`define PRC_ADD_PREV 2'h2
`define PRC_ADD_AB 2'h3

`define PRC_PREV_RESET 32'h0000_0000
`define PRC_BYTE_ZERO 8'h00
`define PRC_WORD_ZERO 32'h0000_0000
`define PRC_HALF_ZERO 16'h0000

`endif

// ==== include/prc_pkg.sv ====
// types shared by the previous-result capture block
// assumes prc_regs.svh is compiled alongside
package prc_pkg;

    typedef struct packed {
        logic [31:0] prev;
        logic [15:0] opa;
        logic mode;
        logic [1:0] mul_src;
        logic [1:0] add_src;
        logic [7:0] rdata;
        logic [15:0] mult_b;
        logic [31:0] addend;
    } prc_state_t;

endpackage : prc_pkg

// ==== src/prc_capture.sv ====
// previous-result capture register with its feedback operand paths
// all state but the reset synchroniser sits in one registered struct, outputs straight from it
// assumes the arithmetic result and the b/c operands come from logic on
// mclk; software drives the plain register port on the same clock
// the multiplier and adder themselves live outside this block

`include "prc_regs.svh"

module prc_capture (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // arithmetic unit side
    input wire logic [31:0] arith_result,
    input wire logic [15:0] operand_b,
    input wire logic [31:0] operand_c,
    // feedback and configuration outputs
    output logic [31:0] previous_result,
    output logic [15:0] operand_a,
    output logic [15:0] mult_operand,
    output logic [31:0] addend_operand,
    output logic capture_mode_select,
    output logic [1:0] multiply_source_select,
    output logic [1:0] addend_source_select
);

    // reset synchroniser stages
    logic rst_sync1_n_q;
    logic rst_n_q;

    // state register and its next value
    prc_pkg::prc_state_t s_q;
    prc_pkg::prc_state_t s_d;

    // per-byte lanes of the captured value, one per result byte address;
    // they keep the readback mux free of index arithmetic
    // (lanes are plain wires, no extra flops)
    logic [`PRC_LANE_W-1:0] prev_lane [`PRC_LANES];

    for (genvar k = 0; k < `PRC_LANES; k++) begin : g_lane
        assign prev_lane[k] = s_q.prev[`PRC_LANE_W*k +: `PRC_LANE_W];
    end

    // reset release through two flops; assertion stays asynchronous
    // without them a release could reach the state flops anywhere in
    // the clock period and split one register between two states
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rst_sync1_n_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_sync1_n_q <= 1'b1;
            rst_n_q <= rst_sync1_n_q;
        end
    end

    // write decode and load qualifiers
    logic wr_cfg;
    logic wr_opa_lo;
    logic wr_opa_hi;
    logic new_mode;
    logic auto_load;
    logic manual_load;
    logic load;
    // next value of operand a
    logic [15:0] opa_next;

    // strobes are one cycle wide, so decode needs no edge detection
    // no write decode exists for the read-only bytes
    always_comb begin
        wr_cfg = reg_wr && (reg_addr == `PRC_ADDR_CONFIG);
        wr_opa_lo = reg_wr && (reg_addr == `PRC_ADDR_OPA_LO);
        wr_opa_hi = reg_wr && (reg_addr == `PRC_ADDR_OPA_HI);
        // a config write takes effect with its own new mode
        // so one write can switch to manual and request together
        new_mode = wr_cfg ? reg_wdata[`PRC_CFG_MODE_BIT] : s_q.mode;
        // auto load path
        // operand writes see the stored mode, never one written now
        auto_load = wr_opa_lo && (s_q.mode == `PRC_MODE_AUTO);
        manual_load = wr_cfg && reg_wdata[`PRC_CFG_REQ_BIT]
            && (new_mode == `PRC_MODE_MANUAL);
        // a request with the auto mode bit in the same write is dropped
        // one strobe, one address: the two sources never coincide
        load = auto_load || manual_load;
    end

    // operand a bytes; only the low byte can trigger a capture
    always_comb begin
        opa_next = s_q.opa;
        if (wr_opa_lo) begin
            opa_next[7:0] = reg_wdata;
        end
        if (wr_opa_hi) begin
            opa_next[15:8] = reg_wdata;
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.opa = opa_next;

        // configuration fields take the written value at once
        if (wr_cfg) begin
            s_d.mode = reg_wdata[`PRC_CFG_MODE_BIT];
            s_d.mul_src = reg_wdata[`PRC_CFG_MUL_MSB:`PRC_CFG_MUL_LSB];
            s_d.add_src = reg_wdata[`PRC_CFG_ADD_MSB:`PRC_CFG_ADD_LSB];
        end

        // request bit is never stored: it acts only in its write cycle,
        // and bits 7:6 of a config write are dropped
        // whole result copied
        if (load) begin
            s_d.prev = arith_result;
        end

        // read data stands only in the cycle after the strobe
        // no snapshot: each byte reads the live value, so bytes read
        // across a capture may come from two different results
        s_d.rdata = `PRC_BYTE_ZERO;
        if (reg_rd) begin
            unique case (reg_addr)
                `PRC_ADDR_PREV0: s_d.rdata = prev_lane[0];
                `PRC_ADDR_PREV1: s_d.rdata = prev_lane[1];
                `PRC_ADDR_PREV2: s_d.rdata = prev_lane[2];
                `PRC_ADDR_PREV3: s_d.rdata = prev_lane[3];
                `PRC_ADDR_CONFIG: begin
                    // request bit always reads back as zero
                    // and bits 7:6 are reserved, also zero
                    s_d.rdata[`PRC_CFG_MODE_BIT] = s_q.mode;
                    s_d.rdata[`PRC_CFG_MUL_MSB:`PRC_CFG_MUL_LSB] =
                        s_q.mul_src;
                    s_d.rdata[`PRC_CFG_ADD_MSB:`PRC_CFG_ADD_LSB] =
                        s_q.add_src;
                end
                // operand a reads back as written
                `PRC_ADDR_OPA_LO: s_d.rdata = s_q.opa[7:0];
                `PRC_ADDR_OPA_HI: s_d.rdata = s_q.opa[15:8];
                default: s_d.rdata = `PRC_BYTE_ZERO;
            endcase
        end

        // operand muxes use the registered state, one cycle behind
        // so a capture or config write reaches these outputs two edges
        // after its strobe; software leaves that gap before relying
        // on a fed-back operand
        // multiplier feedback select
        unique case (s_q.mul_src)
            // plain product with the external operand
            `PRC_MUL_A_B: s_d.mult_b = operand_b;
            // square of operand a
            `PRC_MUL_A_A: s_d.mult_b = s_q.opa;
            // feedback: only the low half of the stored result fits
            `PRC_MUL_A_PREV: s_d.mult_b = s_q.prev[15:0];
            // second code for the square, kept for compatibility
            `PRC_MUL_A_A_ALT: s_d.mult_b = s_q.opa;
        endcase

        unique case (s_q.add_src)
            // no accumulation: adding zero keeps the product as is
            `PRC_ADD_NONE: s_d.addend = `PRC_WORD_ZERO;
            // external operand c
            `PRC_ADD_C: s_d.addend = operand_c;
            // feedback: the full stored result
            `PRC_ADD_PREV: s_d.addend = s_q.prev;
            // operands a and b joined into one 32-bit word
            `PRC_ADD_AB: s_d.addend = {s_q.opa, operand_b};
        endcase
    end

    // cleared at reset
    // feedback paths restart from zero, so the first operation after
    // reset sees a cleared previous value
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            s_q.prev <= `PRC_PREV_RESET;
            s_q.opa <= `PRC_HALF_ZERO;
            s_q.mode <= `PRC_MODE_AUTO;
            s_q.mul_src <= `PRC_MUL_A_B;
            s_q.add_src <= `PRC_ADD_NONE;
            s_q.rdata <= `PRC_BYTE_ZERO;
            s_q.mult_b <= `PRC_HALF_ZERO;
            s_q.addend <= `PRC_WORD_ZERO;
        end else begin
            s_q <= s_d;
        end
    end

    // every output is a field of the state register, nothing after it
    assign reg_rdata = s_q.rdata;
    assign previous_result = s_q.prev;
    assign operand_a = s_q.opa;
    assign mult_operand = s_q.mult_b;
    assign addend_operand = s_q.addend;
    assign capture_mode_select = s_q.mode;
    assign multiply_source_select = s_q.mul_src;
    assign addend_source_select = s_q.add_src;

endmodule : prc_capture

// ==== test/prc_capture_asserts.sv ====
// checker for the previous-result capture block
// assumes it is bound to prc_capture on mclk
module prc_capture_asserts (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // arithmetic side
    input wire logic [31:0] arith_result,
    input wire logic [31:0] previous_result,
    input wire logic [15:0] mult_operand,
    input wire logic [31:0] addend_operand,
    input wire logic capture_mode_select,
    input wire logic [1:0] multiply_source_select,
    input wire logic [1:0] addend_source_select
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    logic auto_ld, man_ld;
    // mode is the old one for operand writes
    assign auto_ld = reg_wr && reg_addr == 8'hc9 && !capture_mode_select;
    assign man_ld = reg_wr && reg_addr == 8'hc8 && reg_wdata[1:0] == 2'h3;
    auto_load_a: assert property (
        auto_ld |=> previous_result == $past(arith_result))
        else $error("auto load wrong");
    manual_load_a: assert property (
        man_ld |=> previous_result == $past(arith_result))
        else $error("manual load wrong");
    prev_hold_a: assert property (
        !(auto_ld || man_ld) |=> $stable(previous_result))
        else $error("value moved");
    ro_write_a: assert property (
        reg_wr && reg_addr[7:2] == 6'h31 |=> $stable(previous_result))
        else $error("read-only byte written");
    read_low_a: assert property (
        reg_rd && reg_addr == 8'hc4 |=> reg_rdata == previous_result[7:0])
        else $error("low byte read wrong");
    read_top_a: assert property (
        reg_rd && reg_addr == 8'hc7 |=> reg_rdata == previous_result[31:24])
        else $error("top byte read wrong");
    mul_prev_a: assert property (
        multiply_source_select == 2'h2
        |=> mult_operand == $past(previous_result[15:0]))
        else $error("multiplier operand wrong");
    add_prev_a: assert property (
        addend_source_select == 2'h2
        |=> addend_operand == $past(previous_result))
        else $error("addend wrong");
    auto_c: cover property (auto_ld);
    man_c: cover property (man_ld);
    mul_c: cover property (multiply_source_select == 2'h2);
endmodule : prc_capture_asserts

bind prc_capture prc_capture_asserts i_prc_capture_asserts (
    .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .arith_result(arith_result),
    .previous_result(previous_result), .mult_operand(mult_operand),
    .addend_operand(addend_operand),
    .capture_mode_select(capture_mode_select),
    .multiply_source_select(multiply_source_select),
    .addend_source_select(addend_source_select));

// ==== test/tb.sv ====
// self-checking bench for the previous-result capture block
// drives the register port and result input on mclk
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, resetn = 0, reg_wr = 0, reg_rd = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, v;
    logic [31:0] arith_result = 32'h0, previous_result, addend_operand;
    logic [15:0] mult_operand, operand_a;
    logic capture_mode_select;
    logic [1:0] multiply_source_select, addend_source_select;
    int err_count = 0, checked = 0, cyc = 0;
    always #25 mclk = ~mclk;
    prc_capture i_prc_capture (.mclk(mclk), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .arith_result(arith_result), .operand_b(16'h4411),
        .operand_c(32'h1111_1111), .previous_result(previous_result),
        .operand_a(operand_a), .mult_operand(mult_operand),
        .addend_operand(addend_operand),
        .capture_mode_select(capture_mode_select),
        .multiply_source_select(multiply_source_select),
        .addend_source_select(addend_source_select));
    task automatic chk(input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("Error t=%0t seen %h exp %h", $time, s, e);
        end
    endtask : chk
    // each write also presents a new arithmetic result
    task automatic wr(input logic [7:0] a, d, input logic [31:0] r);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        arith_result <= r;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(negedge mclk);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        v = reg_rdata;
    endtask : rd
    task automatic rd_all(input logic [31:0] e);
        for (int i = 0; i < 4; i++) begin
            rd(8'hc4 + 8'(i));
            chk({24'h0, v}, {24'h0, e[8*i +: 8]});
        end
    endtask : rd_all
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_count++;
            end_of_test;
        end
    end
    initial begin
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        repeat (3) @(posedge mclk);
        rd_all(32'h0);
        $display("test reset done");
        wr(8'hc9, 8'h22, 32'h1234_5678);
        chk({16'h0, operand_a}, 32'h0000_0022);
        wr(8'hca, 8'h33, 32'h9999_9999);
        chk({16'h0, operand_a}, 32'h0000_3322);
        rd_all(32'h1234_5678);
        @(negedge mclk);
        chk({24'h0, reg_rdata}, 32'h0);
        wr(8'hc4, 8'hff, 32'hdead_beef);
        wr(8'hc8, 8'h01, 32'h0bad_f00d);
        chk({31'h0, capture_mode_select}, 32'h1);
        wr(8'hc9, 8'h22, 32'h0bad_f00d);
        chk(previous_result, 32'h1234_5678);
        wr(8'hc8, 8'h03, 32'h0bad_f00d);
        chk(previous_result, 32'h0bad_f00d);
        rd(8'hc8);
        chk({24'h0, v}, 32'h1);
        wr(8'hc8, 8'h02, 32'h5555_aaaa);
        chk(previous_result, 32'h0bad_f00d);
        wr(8'hc9, 8'h22, 32'h8765_4321);
        chk(previous_result, 32'h8765_4321);
        $display("test load done");
        wr(8'hc8, 8'h28, 32'h8765_4321);
        repeat (2) @(negedge mclk);
        chk({16'h0, mult_operand}, 32'h0000_4321);
        chk(addend_operand, 32'h8765_4321);
        chk({30'h0, multiply_source_select}, 32'h2);
        chk({30'h0, addend_source_select}, 32'h2);
        rd(8'hc8);
        chk({24'h0, v}, 32'h28);
        wr(8'hc8, 8'h14, 32'h8765_4321);
        repeat (2) @(negedge mclk);
        chk({16'h0, mult_operand}, 32'h0000_3322);
        chk(addend_operand, 32'h1111_1111);
        wr(8'hc8, 8'h3c, 32'h8765_4321);
        repeat (2) @(negedge mclk);
        chk({16'h0, mult_operand}, 32'h0000_3322);
        chk(addend_operand, 32'h3322_4411);
        wr(8'hc8, 8'h00, 32'h8765_4321);
        repeat (2) @(negedge mclk);
        chk({16'h0, mult_operand}, 32'h0000_4411);
        chk(addend_operand, 32'h0);
        wr(8'hc0, 8'h5a, 32'hffff_0000);
        rd(8'hc0);
        chk({24'h0, v}, 32'h0);
        rd_all(32'h8765_4321);
        $display("test feedback done");
        end_of_test;
    end
endmodule : tb
